// ===== design/mlfg_guard.sv
// lock detectors, fault sequencer, surge guard, dead time and pwm for the motor bridge
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mlfg_guard
  import mlfg_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = PERSIST_CYC,
  parameter int unsigned RETRY_CYCLES   = RETRY_CYC
) (
  // clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  // register port
  input  wire logic [7:0]   i_addr,
  input  wire logic [7:0]   i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic      [7:0]   o_rdata,
  // motor measurements and events
  input  wire mlfg_meas_s   i_meas,
  input  wire mlfg_evt_s    i_evt,
  input  wire logic         i_restart,
  input  wire logic [7:0]   i_speed_cmd,
  input  wire logic [23:0]  i_phase_duty,
  input  wire logic         i_speed_pulse,
  // bridge and status
  output mlfg_bridge_s      o_bridge,
  output logic [7:0]        o_applied_cmd,
  output logic              o_surge_active,
  output logic              o_restart,
  output logic              o_speed_pulse_output
);

  // configuration registers
  logic [5:0]  enables_q;
  logic [7:0]  limits_q;
  logic [6:0]  res_q;
  logic [6:0]  kconst_q;
  logic [7:0]  drive_q;
  logic [7:0]  rdata_q;
  logic [5:0]  cause_q;
  logic        locked_q;
  mlfg_state_e state_q;

  wire [2:0] lock_current_threshold = limits_q[LIM_THR_LSB +: 3];
  wire [1:0] constant_window_select = limits_q[LIM_WIN_LSB +: 2];
  wire       mech_surge_guard_enable      = drive_q[DRV_MECH_EN];
  wire       inductive_surge_guard_enable = drive_q[DRV_IND_EN];
  wire       mech_surge_guard_mode        = drive_q[DRV_MECH_MD];
  wire       pwm_rate_double              = drive_q[DRV_RATE_DBL];
  wire [3:0] dead_sel                     = drive_q[DRV_DT_LSB +: 4];

  wire       running   = (state_q == ST_RUN);
  wire       wr_en     = i_ce & i_wr;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enables_q <= RST_ENABLES;
      limits_q  <= RST_LIMITS;
      res_q     <= RST_RES;
      kconst_q  <= RST_KCONST;
      drive_q   <= RST_DRIVE;
    end else if (wr_en) begin
      if (i_addr == ADDR_ENABLES) enables_q <= i_wdata[5:0];
      if (i_addr == ADDR_LIMITS)  limits_q  <= i_wdata & 8'h37;
      if (i_addr == ADDR_RES)     res_q     <= i_wdata[6:0];
      if (i_addr == ADDR_KCONST)  kconst_q  <= i_wdata[6:0];
      if (i_addr == ADDR_DRIVE)   drive_q   <= i_wdata;
    end
  end

  // read mux, answered in the next cycle
  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      ADDR_ENABLES: rd_mux = {2'h0, enables_q};
      ADDR_LIMITS:  rd_mux = limits_q;
      ADDR_RES:     rd_mux = {1'h0, res_q};
      ADDR_KCONST:  rd_mux = {1'h0, kconst_q};
      ADDR_DRIVE:   rd_mux = drive_q;
      ADDR_STATUS:  rd_mux = {6'h0, ~running, locked_q};
      ADDR_CAUSE:   rd_mux = {2'h0, cause_q};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) rdata_q <= 8'h00;
    else if (i_ce) rdata_q <= i_rd ? rd_mux : 8'h00;
  end
  assign o_rdata = rdata_q;

  // back-EMF estimates
  wire [18:0] bemf_speed_w = i_meas.speed * kconst_q;
  wire [18:0] ir_drop_w    = i_meas.u_current_ma * res_q;
  wire [12:0] bemf_speed   = bemf_speed_w[18:6];
  wire [12:0] bemf_current = {1'b0, i_meas.amplitude} + {1'b0, ir_drop_w[18:7]};
  wire [12:0] amp_twice    = {i_meas.amplitude, 1'b0};

  // detector 0: low-side current trip
  wire trip_current = i_meas.lowside_current > {lock_current_threshold, 5'h1f};

  // detector 1: back-EMF far above output amplitude
  wire speed_raw = (bemf_speed > amp_twice) & (bemf_current > amp_twice);

  // detector 2: integral outside window around programmed constant
  wire [15:0] k_ref    = {1'b0, kconst_q, 8'h00};
  wire [15:0] k_margin = k_ref >> (2'd3 - constant_window_select);
  wire [16:0] k_high   = {1'b0, k_ref} + {1'b0, k_margin};
  wire [15:0] k_low    = k_ref - k_margin;
  wire const_raw = i_evt.closed_loop &
                   (({1'b0, i_meas.bemf_integral} > k_high) | (i_meas.bemf_integral < k_low));

  // persistence filters for detectors 1 and 2
  logic [31:0] speed_cnt_q;
  logic [31:0] const_cnt_q;
  wire trip_speed = speed_cnt_q >= PERSIST_CYCLES;
  wire trip_const = const_cnt_q >= PERSIST_CYCLES;

  function automatic logic [31:0] persist_next(input logic raw, input logic [31:0] cnt);
    if (!raw) persist_next = 32'h0;
    else if (cnt >= PERSIST_CYCLES) persist_next = cnt;
    else persist_next = cnt + 32'h1;
  endfunction : persist_next

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      speed_cnt_q <= 32'h0;
      const_cnt_q <= 32'h0;
    end else if (i_ce) begin
      speed_cnt_q <= persist_next(speed_raw & running, speed_cnt_q);
      const_cnt_q <= persist_next(const_raw & running, const_cnt_q);
    end
  end

  // detector 3: no motor after handoff
  wire trip_nomotor = i_evt.handoff & (i_meas.u_current_ma <= NO_MOTOR_MA);

  // detector 4: open-loop stall, one electrical cycle window
  logic ol_arm_q;
  logic ol_win_q;
  logic ol_seen_q;
  wire  ol_active  = i_evt.open_loop & i_evt.rate_over & running;
  wire  trip_olstall = ol_win_q & i_evt.ecycle_tick & ~ol_seen_q & ~i_evt.zero_cross;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ol_arm_q  <= 1'b0;
      ol_win_q  <= 1'b0;
      ol_seen_q <= 1'b0;
    end else if (i_ce) begin
      ol_arm_q <= ol_active;
      if (!ol_active) begin
        ol_win_q  <= 1'b0;
        ol_seen_q <= 1'b0;
      end else if (!ol_arm_q) begin
        ol_win_q  <= 1'b1;
        ol_seen_q <= i_evt.zero_cross;
      end else if (ol_win_q) begin
        ol_seen_q <= ol_seen_q | i_evt.zero_cross;
        if (i_evt.ecycle_tick) ol_win_q <= 1'b0;
      end
    end
  end

  // detector 5: closed-loop stall, period over twice the previous one
  logic [19:0] comm_cnt_q;
  logic [19:0] comm_prev_q;
  wire  [20:0] prev_twice = {comm_prev_q, 1'b0};
  wire  cl_watch   = i_evt.closed_loop & running & (comm_prev_q != 20'h0);
  wire  trip_clstall = cl_watch & ({1'b0, comm_cnt_q} > prev_twice);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      comm_cnt_q  <= 20'h0;
      comm_prev_q <= 20'h0;
    end else if (i_ce) begin
      if (!i_evt.closed_loop || !running) begin
        comm_cnt_q  <= 20'h0;
        comm_prev_q <= 20'h0;
      end else if (i_evt.commutate) begin
        comm_prev_q <= comm_cnt_q;
        comm_cnt_q  <= 20'h0;
      end else if (comm_cnt_q != STALL_MAX) begin
        comm_cnt_q <= comm_cnt_q + 20'h1;
      end
    end
  end

  // fault combining
  wire [5:0] det_raw = {trip_clstall, trip_olstall, trip_nomotor, trip_const, trip_speed, trip_current};
  wire [5:0] det     = det_raw & {6{running}};
  wire       fault   = |(det & enables_q);

  // sequencer: run, surge guard, wait, restart
  logic [11:0] surge_cnt_q;
  logic [31:0] wait_cnt_q;
  logic        restart_q;
  wire         surge_done = (surge_cnt_q == 12'h0);
  wire         wait_done  = (wait_cnt_q >= RETRY_CYCLES);
  wire         auto_restart = (state_q == ST_WAIT) & wait_done;
  wire         restart_evt  = auto_restart | i_restart;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q     <= ST_RUN;
      surge_cnt_q <= 12'h0;
      wait_cnt_q  <= 32'h0;
      restart_q   <= 1'b0;
    end else if (i_ce) begin
      restart_q <= auto_restart;
      case (state_q)
        ST_RUN: begin
          if (fault) begin
            state_q     <= ST_SURGE;
            surge_cnt_q <= inductive_surge_guard_enable ? SURGE_CYC : 12'h0;
          end
        end
        ST_SURGE: begin
          if (surge_done) begin
            state_q    <= ST_WAIT;
            wait_cnt_q <= 32'h0;
          end else begin
            surge_cnt_q <= surge_cnt_q - 12'h1;
          end
        end
        ST_WAIT: begin
          if (wait_done) state_q <= ST_RUN;
          else wait_cnt_q <= wait_cnt_q + 32'h1;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end
  assign o_restart = restart_q;

  // cause flags and locked status, a new detection beats the restart clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cause_q  <= 6'h00;
      locked_q <= 1'b0;
    end else if (i_ce) begin
      cause_q  <= (restart_evt ? 6'h00 : cause_q) | det;
      locked_q <= fault | (locked_q & ~restart_evt);
    end
  end

  // mechanical surge guard: buffered command clamped to back-EMF
  wire [7:0] bemf_cmd   = (bemf_speed[12:4] > 9'h0ff) ? 8'hff : bemf_speed[11:4];
  wire       mech_armed = mech_surge_guard_enable &
                          (~mech_surge_guard_mode | (i_meas.supply >= SUPPLY_24V_CODE));
  wire [7:0] clamp_cmd  = (mech_armed & (i_speed_cmd < bemf_cmd)) ? bemf_cmd : i_speed_cmd;
  logic [7:0] cmd_buf_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) cmd_buf_q <= 8'h00;
    else if (i_ce) cmd_buf_q <= clamp_cmd;
  end
  assign o_applied_cmd = cmd_buf_q;

  // pwm carrier
  logic [12:0] pwm_cnt_q;
  wire  [12:0] pwm_period = pwm_rate_double ? PWM_PERIOD_DBL : PWM_PERIOD_CYC;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) pwm_cnt_q <= 13'h0;
    else if (i_ce) pwm_cnt_q <= (pwm_cnt_q >= pwm_period - 13'h1) ? 13'h0 : pwm_cnt_q + 13'h1;
  end

  // dead time in cycles: (sel+1) * 40 ns
  wire [6:0] dead_cyc = 7'({3'h0, dead_sel} + 7'h1) * DT_STEP_CYC;

  logic         hiz_q;
  wire          drive_off = ~running;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      wire [28:0] scaled = pwm_period * i_phase_duty[ph*8 +: 8] * cmd_buf_q;
      // duty and command are both fractions of 256, so the product drops 16 bits
      wire        want_high = pwm_cnt_q < scaled[28:16];
      logic       level_q;
      logic [6:0] dt_q;
      logic       hi_q;
      logic       lo_q;
      wire        settled = (dt_q == 7'h0);

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          level_q <= 1'b0;
          dt_q    <= 7'h0;
        end else if (i_ce) begin
          level_q <= want_high;
          // the count down to zero costs one cycle, so load one less
          if (want_high != level_q) dt_q <= dead_cyc - 7'h1;
          else if (!settled) dt_q <= dt_q - 7'h1;
        end
      end

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          hi_q <= 1'b0;
          lo_q <= 1'b0;
        end else if (i_ce) begin
          hi_q <= ~drive_off & settled & level_q & (want_high == level_q);
          lo_q <= (state_q == ST_SURGE) |
                  (~drive_off & settled & ~level_q & (want_high == level_q));
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) hiz_q <= 1'b0;
    else if (i_ce) hiz_q <= (state_q == ST_WAIT);
  end
  assign o_bridge       = '{high_on: {g_phase[2].hi_q, g_phase[1].hi_q, g_phase[0].hi_q},
                            low_on:  {g_phase[2].lo_q, g_phase[1].lo_q, g_phase[0].lo_q},
                            hiz:     hiz_q};
  assign o_surge_active = (state_q == ST_SURGE) | (mech_armed & (clamp_cmd != i_speed_cmd));

  // speed pulse held high while locked
  logic spo_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) spo_q <= 1'b0;
    else if (i_ce) spo_q <= locked_q | i_speed_pulse;
  end
  assign o_speed_pulse_output = spo_q;

endmodule : mlfg_guard

// ===== design/mlfg_pkg.sv
// constants, field layouts and carrier types for the motor lock and fault guard
// What this block does
// - six enable bits, one per lock detector plus no-motor, each disables its detector.
// - any enabled lock detection sets the motor locked status bit.
// - one cause flag per detector, set on detection even when that detector is disabled.
// - all cause flags clear when the motor restarts.
// - locked rotor or no motor puts every phase driver into high impedance.
// - every move to high impedance runs the surge guard sequence first.
// - after a fault tristate, wait the retry time, then restart automatically.
// - low-side current above the three-bit threshold stops drive, tristates and flags lock.
// - back-EMF from current and resistance, and from speed and constant; abnormal speed.
// - back-EMF half-cycle integral outside the selected window for persist time is lock.
// - after open-to-closed handoff, U current not above 140 mA is a no-motor fault.
// - open loop above handoff rate, no back-EMF within one electrical cycle is lock.
// - closed loop commutation period over twice the previous one is a stall lock.
// - separate enables for mechanical and inductive surge protection.
// - mechanical guard buffers speed command and clamps output to at least back-EMF.
// - mechanical guard mode 0 always active, mode 1 only once supply reaches 24 V.
// - sixteen dead times, 40 ns to 640 ns, from a four-bit field.
// - PWM runs at 25 kHz, or 50 kHz when the rate-double bit is set.
// - speed pulse output held high while locked.
package mlfg_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_NS = 8;

  // register offsets
  localparam logic [7:0] ADDR_ENABLES = 8'h00;
  localparam logic [7:0] ADDR_LIMITS  = 8'h01;
  localparam logic [7:0] ADDR_RES     = 8'h02;
  localparam logic [7:0] ADDR_KCONST  = 8'h03;
  localparam logic [7:0] ADDR_DRIVE   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h05;
  localparam logic [7:0] ADDR_CAUSE   = 8'h06;

  // field positions
  localparam int unsigned LIM_THR_LSB  = 0;
  localparam int unsigned LIM_WIN_LSB  = 4;
  localparam int unsigned DRV_MECH_EN  = 0;
  localparam int unsigned DRV_IND_EN   = 1;
  localparam int unsigned DRV_MECH_MD  = 2;
  localparam int unsigned DRV_RATE_DBL = 3;
  localparam int unsigned DRV_DT_LSB   = 4;
  localparam int unsigned STS_LOCKED   = 0;
  localparam int unsigned STS_HIZ      = 1;

  // reset values
  localparam logic [5:0] RST_ENABLES = 6'h3f;
  localparam logic [7:0] RST_LIMITS  = 8'h07;
  localparam logic [6:0] RST_RES     = 7'h00;
  localparam logic [6:0] RST_KCONST  = 7'h00;
  localparam logic [7:0] RST_DRIVE   = 8'h03;

  // detector indices
  localparam int unsigned DET_CURRENT = 0;
  localparam int unsigned DET_SPEED   = 1;
  localparam int unsigned DET_CONST   = 2;
  localparam int unsigned DET_NOMOTOR = 3;
  localparam int unsigned DET_OLSTALL = 4;
  localparam int unsigned DET_CLSTALL = 5;
  localparam int unsigned NUM_DET     = 6;

  // analog thresholds in measurement codes
  localparam logic [11:0] NO_MOTOR_MA    = 12'h08c;
  localparam int unsigned SUPPLY_MV_FS   = 30_000;
  localparam int unsigned SURGE_MODE_MV  = 24_000;
  localparam logic [7:0]  SUPPLY_24V_CODE =
    8'((SURGE_MODE_MV * 256 + SUPPLY_MV_FS - 1) / SUPPLY_MV_FS);

  // pwm and dead time
  localparam int unsigned PWM_BASE_HZ = 25_000;
  localparam logic [12:0] PWM_PERIOD_CYC = 13'(CLK_HZ / PWM_BASE_HZ);
  localparam logic [12:0] PWM_PERIOD_DBL = 13'(CLK_HZ / (2 * PWM_BASE_HZ));
  localparam int unsigned DT_STEP_NS  = 40;
  localparam logic [6:0]  DT_STEP_CYC = 7'((DT_STEP_NS + CLK_NS - 1) / CLK_NS);

  // timing (defaults only, no figure given for these)
  localparam int unsigned PERSIST_US   = 100_000;
  localparam int unsigned PERSIST_CYC  = PERSIST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RETRY_US     = 500_000;
  localparam int unsigned RETRY_CYC    = RETRY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SURGE_NS     = 2_000;
  localparam logic [11:0] SURGE_CYC    = 12'(SURGE_NS / CLK_NS);
  localparam logic [19:0] STALL_MAX    = 20'hfffff;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SURGE,
    ST_WAIT
  } mlfg_state_e;

  typedef struct packed {
    logic [7:0]  lowside_current;
    logic [11:0] u_current_ma;
    logic [11:0] speed;
    logic [11:0] amplitude;
    logic [15:0] bemf_integral;
    logic [7:0]  supply;
  } mlfg_meas_s;

  typedef struct packed {
    logic open_loop;
    logic closed_loop;
    logic rate_over;
    logic handoff;
    logic zero_cross;
    logic ecycle_tick;
    logic commutate;
  } mlfg_evt_s;

  typedef struct packed {
    logic [2:0] high_on;
    logic [2:0] low_on;
    logic       hiz;
  } mlfg_bridge_s;

endpackage : mlfg_pkg

// ===== testbench/mlfg_guard_asserts.sv
// concurrent checks on the motor lock and fault guard ports
`timescale 1ns/1ps
module mlfg_guard_asserts
  import mlfg_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = 20,
  parameter int unsigned RETRY_CYCLES   = 40
) (
  // clock and reset
  input wire logic         i_clk,
  input wire logic         i_rst_b,
  input wire logic         i_ce,
  // observed ports
  input wire logic         i_rd,
  input wire logic [7:0]   o_rdata,
  input wire mlfg_bridge_s o_bridge,
  input wire logic         o_surge_active,
  input wire logic         o_restart,
  input wire logic         o_speed_pulse_output
);
  logic [15:0] hiz_cnt_q;

  // consecutive cycles with the bridge released
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) hiz_cnt_q <= 16'h0000;
    else if (!o_bridge.hiz) hiz_cnt_q <= 16'h0000;
    else if (hiz_cnt_q != 16'hffff) hiz_cnt_q <= hiz_cnt_q + 16'h0001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_hiz_no_drive: assert property (o_bridge.hiz |-> (o_bridge.high_on == 3'h0) && (o_bridge.low_on == 3'h0))
    else $error("bridge driven while released");
  a_no_shoot: assert property ((o_bridge.high_on & o_bridge.low_on) == 3'h0)
    else $error("both fets of one phase on");
  a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  a_surge_first: assert property ($rose(o_bridge.hiz) |-> $past(o_surge_active, 2) || $past(o_surge_active, 3))
    else $error("tristate without surge guard");
  a_hiz_hold: assert property ($rose(o_bridge.hiz) |-> o_bridge.hiz [*8])
    else $error("tristate wait cut short");
  a_retry_wait: assert property (o_restart |-> hiz_cnt_q >= 16'(RETRY_CYCLES - 2) && hiz_cnt_q <= 16'(RETRY_CYCLES + 1))
    else $error("retry not after the wait time");
  a_restart_pulse: assert property (o_restart |=> !o_restart)
    else $error("restart pulse longer than one cycle");
  a_lock_fg_high: assert property ($rose(o_bridge.hiz) |-> o_speed_pulse_output)
    else $error("speed pulse output not high while locked");

  c_restart: cover property (o_restart);
  c_hiz: cover property ($rose(o_bridge.hiz));
  c_read: cover property (i_rd ##1 o_rdata != 8'h00);
endmodule : mlfg_guard_asserts

bind mlfg_guard mlfg_guard_asserts #(
  .PERSIST_CYCLES(PERSIST_CYCLES),
  .RETRY_CYCLES  (RETRY_CYCLES)
) mlfg_guard_asserts_i (
  .i_clk               (i_clk),
  .i_rst_b             (i_rst_b),
  .i_ce                (i_ce),
  .i_rd                (i_rd),
  .o_rdata             (o_rdata),
  .o_bridge            (o_bridge),
  .o_surge_active      (o_surge_active),
  .o_restart           (o_restart),
  .o_speed_pulse_output(o_speed_pulse_output)
);

// ===== testbench/mlfg_motor_model.sv
// behavioural windings: low-side current only flows through a driven low fet
`timescale 1ns/1ps
module mlfg_motor_model
  import mlfg_pkg::*;
(
  // bridge from the block
  input  wire mlfg_bridge_s i_bridge,
  // load knobs
  input  wire logic [7:0]   i_load,
  input  wire logic [11:0]  i_u_ma,
  input  wire logic [7:0]   i_supply,
  input  wire logic         i_handoff,
  // measurements back
  output mlfg_meas_s        o_meas,
  output mlfg_evt_s         o_evt
);
  wire lo_driven = (|i_bridge.low_on) && !i_bridge.hiz;

  // a released bridge carries no current
  assign o_meas = '{lowside_current: lo_driven ? i_load : 8'h00,
                    u_current_ma: i_u_ma, speed: 12'h800, amplitude: 12'h000,
                    bemf_integral: 16'h0000, supply: i_supply};
  // loops idle so only the low-side current trip and the handoff check can see a fault
  assign o_evt = '{open_loop: 1'b0, closed_loop: 1'b0, rate_over: 1'b0, handoff: i_handoff,
                   zero_cross: 1'b0, ecycle_tick: 1'b0, commutate: 1'b0};
endmodule : mlfg_motor_model

// ===== testbench/mlfg_guard_tb.sv
// self-checking bench for the motor lock and fault guard
`timescale 1ns/1ps
module mlfg_guard_tb;
  import mlfg_pkg::*;
  logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, i_restart = 0, i_speed_pulse = 0, handoff = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, load = 8'h00, supply = 8'h00, o_applied_cmd;
  logic [11:0] u_ma = 12'h200;
  logic o_surge_active, o_restart, o_speed_pulse_output;
  mlfg_meas_s meas;
  mlfg_evt_s evt;
  mlfg_bridge_s o_bridge;
  int num_errors = 0, tests_run = 0, cyc = 0;

  always #4 i_clk = ~i_clk;

  mlfg_guard #(.PERSIST_CYCLES(20), .RETRY_CYCLES(40)) mlfg_guard_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_meas(meas), .i_evt(evt), .i_restart(i_restart),
    .i_speed_cmd(8'h40), .i_phase_duty(24'h808080), .i_speed_pulse(i_speed_pulse), .o_bridge(o_bridge),
    .o_applied_cmd(o_applied_cmd), .o_surge_active(o_surge_active), .o_restart(o_restart),
    .o_speed_pulse_output(o_speed_pulse_output));
  mlfg_motor_model mlfg_motor_model_i (.i_bridge(o_bridge), .i_load(load), .i_u_ma(u_ma),
    .i_supply(supply), .i_handoff(handoff), .o_meas(meas), .o_evt(evt));

  task finish_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    i_speed_pulse <= ~i_speed_pulse;
    if (cyc == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task rd_chk(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d & m});
  endtask : rd_chk
  // waits for a level on hiz (sel 0), restart (1), high fet 0 (2) or low fet 0 (3)
  task wait_lvl(input int sel, input logic v, input int lim, output int n);
    logic [3:0] s;
    n = 0;
    s = {o_bridge.low_on[0], o_bridge.high_on[0], o_restart, o_bridge.hiz};
    while (s[sel] !== v && n < lim) begin
      @(posedge i_clk) #1 n++;
      s = {o_bridge.low_on[0], o_bridge.high_on[0], o_restart, o_bridge.hiz};
    end
    if (n >= lim) chk("wait", 16'h0, 16'h1);
  endtask : wait_lvl

  task t_reset_regs;
    rd_chk("enables", ADDR_ENABLES, 8'h3f, RST_ENABLES);
    rd_chk("limits", ADDR_LIMITS, 8'hff, RST_LIMITS);
    rd_chk("res", ADDR_RES, 8'h7f, {1'b0, RST_RES});
    rd_chk("kconst", ADDR_KCONST, 8'h7f, {1'b0, RST_KCONST});
    rd_chk("drive", ADDR_DRIVE, 8'hff, RST_DRIVE);
    wr(ADDR_CAUSE, 8'h3f);
    rd_chk("cause ro", ADDR_CAUSE, 8'h3f, 8'h00);
    rd_chk("unmapped", 8'h07, 8'hff, 8'h00);
  endtask : t_reset_regs

  task t_current_trip;
    int n;
    wr(ADDR_LIMITS, 8'h02);
    // current only shows while a low fet conducts
    load <= 8'h60;
    wait_lvl(3, 1'b1, 6000, n);
    @(posedge i_clk) load <= 8'h00;
    rd_chk("locked", ADDR_STATUS, 8'h01, 8'h01);
    rd_chk("cause trip", ADDR_CAUSE, 8'h3f, 8'h01);
    wait_lvl(0, 1'b1, 300, n);
    wait_lvl(1, 1'b1, 60, n);
    chk("retry wait", 16'd40, 16'(n));
    rd_chk("cause clear", ADDR_CAUSE, 8'h3f, 8'h00);
    rd_chk("unlocked", ADDR_STATUS, 8'h01, 8'h00);
  endtask : t_current_trip

  task t_disabled_trip;
    int n;
    wr(ADDR_ENABLES, 8'h3e);
    load <= 8'h60;
    wait_lvl(3, 1'b1, 6000, n);
    @(posedge i_clk) load <= 8'h00;
    rd_chk("cause disabled", ADDR_CAUSE, 8'h3f, 8'h01);
    rd_chk("no lock", ADDR_STATUS, 8'h01, 8'h00);
    chk("no hiz", 16'h0, {15'h0, o_bridge.hiz});
    @(posedge i_clk) i_restart <= 1'b1;
    @(posedge i_clk) i_restart <= 1'b0;
    rd_chk("cause restart", ADDR_CAUSE, 8'h3f, 8'h00);
    wr(ADDR_ENABLES, 8'h3f);
  endtask : t_disabled_trip

  task t_no_motor;
    int n;
    u_ma <= NO_MOTOR_MA;
    @(posedge i_clk) handoff <= 1'b1;
    @(posedge i_clk) handoff <= 1'b0;
    rd_chk("no motor", ADDR_CAUSE, 8'h3f, 8'h08);
    wait_lvl(0, 1'b1, 300, n);
    wait_lvl(1, 1'b1, 60, n);
    u_ma <= NO_MOTOR_MA + 12'h001;
    @(posedge i_clk) handoff <= 1'b1;
    @(posedge i_clk) handoff <= 1'b0;
    rd_chk("motor ok", ADDR_CAUSE, 8'h3f, 8'h00);
  endtask : t_no_motor

  task t_surge_modes;
    logic [7:0] cfg [4] = '{8'h00, 8'h05, 8'h05, 8'h01};
    logic [7:0] sup [4] = '{8'hff, SUPPLY_24V_CODE - 8'h01, SUPPLY_24V_CODE, 8'h00};
    // model speed 0x800 times constant 0x40, scaled down by 2^10, gives a back-EMF command of 0x80
    wr(ADDR_KCONST, 8'h40);
    for (int k = 0; k < 4; k++) begin
      supply <= sup[k];
      wr(ADDR_DRIVE, cfg[k]);
      @(posedge i_clk) #1;
      chk("surge active", 16'(k >= 2), {15'h0, o_surge_active});
      chk("applied cmd", (k >= 2) ? 16'h0080 : 16'h0040, {8'h00, o_applied_cmd});
    end
  endtask : t_surge_modes

  task t_pwm;
    int n, a, b;
    logic [7:0] cfg [3] = '{8'h00, 8'h08, 8'hf0};
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_DRIVE, cfg[k]);
      wait_lvl(2, 1'b0, 6000, n);
      wait_lvl(2, 1'b1, 6000, n);
      wait_lvl(2, 1'b0, 6000, a);
      wait_lvl(3, 1'b1, 6000, n);
      chk("dead time", 16'((cfg[k][7:4] + 1) * DT_STEP_CYC), 16'(n));
      wait_lvl(2, 1'b1, 6000, b);
      chk("pwm period", 16'(k == 1 ? PWM_PERIOD_DBL : PWM_PERIOD_CYC), 16'(a + n + b));
    end
  endtask : t_pwm

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset_regs();
    t_current_trip();
    t_disabled_trip();
    t_no_motor();
    t_surge_modes();
    t_pwm();
    finish_test();
  end
endmodule : mlfg_guard_tb
